// ---- verilog/fcp_pkg.sv ----
package fcp_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_INDEX = 8'h00;
  localparam logic [7:0] OFF_DATA = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_EEPROM_PROTECTION = 8'h0C;
  localparam logic [7:0] OFF_SEC = 8'h10;
  // register select codes
  localparam logic [2:0] SEL_INDEX = 3'h0;
  localparam logic [2:0] SEL_DATA = 3'h1;
  localparam logic [2:0] SEL_STATUS = 3'h2;
  localparam logic [2:0] SEL_EEPROM_PROTECTION = 3'h3;
  localparam logic [2:0] SEL_SEC = 3'h4;
  localparam logic [2:0] SEL_NONE = 3'h7;
  // status fields
  localparam int CMPL_BIT = 7;
  localparam int ACC_BIT = 5;
  localparam int PROT_BIT = 4;
  localparam int VERR_HI_BIT = 1;
  localparam int VERR_LO_BIT = 0;
  // eeprom protection fields
  localparam int OPEN_BIT = 7;
  localparam int SIZE_W = 5;
  localparam logic [7:0] EEPROM_PROTECTION_RESET = 8'h80;
  // security fields
  localparam int KEY_LSB = 6;
  localparam logic [1:0] KEY_ENABLED = 2'h2;
  localparam logic [1:0] SEC_UNSECURED = 2'h2;
  localparam logic [7:0] SEC_ALL_SET = 8'hFF;
  // parameter array
  localparam int PARAM_WORDS = 6;
  localparam int IDX_W = 3;
  localparam logic [2:0] IDX_CMD = 3'h0;
  localparam logic [2:0] IDX_ADDR = 3'h1;
  localparam logic [2:0] IDX_LAST = 3'h5;
  // commands and blocks
  localparam logic [7:0] CMD_ERASE_BLOCK = 8'h09;
  localparam logic [7:0] CMD_ERASE_SECTOR = 8'h0A;
  localparam logic [1:0] BLK_EEPROM = 2'h0;
  localparam logic [1:0] BLK_PFLASH = 2'h3;
  localparam logic [63:0] CMD_MODE_DEFAULT = 64'hFFFF_FFFF_FFFF_FFFF;
  // controller states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CHECK = 5'b00010,
    ST_ERASE = 5'b00100,
    ST_VERIFY = 5'b01000,
    ST_DONE = 5'b10000
  } fcp_state_t;
  // request to the array timing logic
  typedef struct packed {
    logic erase;
    logic verify;
    logic sector;
    logic [17:0] addr;
  } fcp_array_req_t;
endpackage

// ---- verilog/fcp_top.sv ----
// Implementation choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module fcp_top #(
  parameter logic [63:0] CMD_MODE_MASK = fcp_pkg::CMD_MODE_DEFAULT
) (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic CFG_LOAD,
  input wire logic [7:0] CFG_EEPROM_PROTECTION_BYTE,
  input wire logic [7:0] CFG_SEC_BYTE,
  input wire logic CFG_SEC_DBL_FAULT,
  input wire logic [1:0] OP_MODE,
  input wire logic PFLASH_PROTECTED,
  input wire logic BACKDOOR_UNSECURE,
  output fcp_pkg::fcp_array_req_t ARRAY_REQ,
  input wire logic ARRAY_DONE,
  input wire logic ARRAY_VERIFY_ERR,
  input wire logic ARRAY_UNCORR_ERR,
  output logic CMD_COMPLETE,
  output logic BACKDOOR_KEY_EN
);
  import fcp_pkg::*;

  logic [PARAM_WORDS-1:0][15:0] param_r;
  logic [IDX_W-1:0] index_r;
  logic [IDX_W-1:0] launch_idx_r;
  logic complete_r;
  logic acc_err_r;
  logic prot_err_r;
  logic verr_hi_r;
  logic verr_lo_r;
  logic eep_open_r;
  logic [SIZE_W-1:0] eep_size_r;
  logic [7:0] sec_r;
  logic wr_pend_r;
  logic [2:0] wr_sel_r;
  logic [1:0] wr_lane_r;
  fcp_state_t state_r;
  fcp_state_t state_nxt;
  logic bus_acc;
  logic launch;
  logic [31:0] rd_nxt;
  logic [7:0] cmd_code;
  logic [17:0] cmd_addr;
  logic chk_acc;
  logic chk_prot;

  // register select from byte address
  function automatic logic [2:0] reg_sel(input logic [31:0] a);
    case (a[7:0] & 8'hFC)
      OFF_INDEX: reg_sel = SEL_INDEX;
      OFF_DATA: reg_sel = SEL_DATA;
      OFF_STATUS: reg_sel = SEL_STATUS;
      OFF_EEPROM_PROTECTION: reg_sel = SEL_EEPROM_PROTECTION;
      OFF_SEC: reg_sel = SEL_SEC;
      default: reg_sel = SEL_NONE;
    endcase
  endfunction

  // byte lanes of the parameter word touched
  function automatic logic [1:0] lane_mask(input logic [2:0] sz, input logic [1:0] a);
    if (sz == 3'h0)
    begin
      lane_mask = {a == 2'h1, a == 2'h0};
    end
    else
    begin
      lane_mask = 2'h3;
    end
  endfunction

  // command allowed in mode
  function automatic logic cmd_allowed(input logic [7:0] c, input logic [1:0] m);
    cmd_allowed = (c[7:4] == 4'h0) && CMD_MODE_MASK[{m, c[3:0]}];
  endfunction

  assign bus_acc = HSEL && HTRANS[1] && HREADY;
  assign launch = wr_pend_r && (wr_sel_r == SEL_STATUS) && HWDATA[CMPL_BIT] && complete_r;
  assign cmd_code = param_r[IDX_CMD][15:8];
  assign cmd_addr = {param_r[IDX_CMD][1:0], param_r[IDX_ADDR]};

  // bus address phase capture
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      wr_pend_r <= 1'b0;
      wr_sel_r <= SEL_NONE;
      wr_lane_r <= 2'h0;
    end
    else
    begin
      wr_pend_r <= bus_acc && HWRITE;
      wr_sel_r <= reg_sel(HADDR);
      wr_lane_r <= lane_mask(HSIZE, HADDR[1:0]);
    end
  end

  // read data mux
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    case (reg_sel(HADDR))
      SEL_INDEX: rd_nxt[IDX_W-1:0] = index_r;
      // results read back; hidden words read zero
      SEL_DATA: rd_nxt[15:0] = (index_r > IDX_LAST) ? 16'h0000 : param_r[index_r];
      SEL_STATUS:
      begin
        rd_nxt[CMPL_BIT] = complete_r;
        rd_nxt[ACC_BIT] = acc_err_r;
        rd_nxt[PROT_BIT] = prot_err_r;
        rd_nxt[VERR_HI_BIT] = verr_hi_r;
        rd_nxt[VERR_LO_BIT] = verr_lo_r;
      end
      SEL_EEPROM_PROTECTION:
      begin
        rd_nxt[OPEN_BIT] = eep_open_r;
        rd_nxt[SIZE_W-1:0] = eep_size_r;
      end
      SEL_SEC: rd_nxt[7:0] = sec_r;
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // bus response
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      HRDATA <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
    else
    begin
      HRDATA <= (bus_acc && !HWRITE) ? rd_nxt : 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  // index register
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      index_r <= 3'h0;
    end
    else if (wr_pend_r && wr_sel_r == SEL_INDEX && wr_lane_r[0])
    begin
      index_r <= HWDATA[IDX_W-1:0];
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      param_r <= '0;
    end
    // locked while busy; hidden words ignored
    else if (wr_pend_r && wr_sel_r == SEL_DATA && complete_r && index_r <= IDX_LAST)
    begin
      if (wr_lane_r[0])
      begin
        param_r[index_r][7:0] <= HWDATA[7:0];
      end
      if (wr_lane_r[1])
      begin
        param_r[index_r][15:8] <= HWDATA[15:8];
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      complete_r <= 1'b1;
      launch_idx_r <= 3'h0;
    end
    else if (state_r == ST_DONE)
    begin
      complete_r <= 1'b1;
    end
    else if (launch)
    begin
      complete_r <= 1'b0;
      launch_idx_r <= index_r;
    end
  end

  // launch checks
  always_comb
  begin
    chk_acc = 1'b0;
    chk_prot = 1'b0;
    // index must point at the address word
    if (launch_idx_r != IDX_ADDR)
    begin
      chk_acc = 1'b1;
    end
    if (!cmd_allowed(cmd_code, OP_MODE))
    begin
      chk_acc = 1'b1;
    end
    if (cmd_code != CMD_ERASE_BLOCK && cmd_code != CMD_ERASE_SECTOR)
    begin
      chk_acc = 1'b1;
    end
    if (cmd_addr[17:16] != BLK_PFLASH &&
        !(cmd_addr[17:16] == BLK_EEPROM && cmd_code == CMD_ERASE_BLOCK))
    begin
      chk_acc = 1'b1;
    end
    if ((cmd_addr[17:16] == BLK_PFLASH && cmd_addr[2:0] != 3'h0) ||
        (cmd_addr[17:16] == BLK_EEPROM && cmd_addr[0]))
    begin
      chk_acc = 1'b1;
    end
    if ((cmd_addr[17:16] == BLK_PFLASH && PFLASH_PROTECTED) ||
        (cmd_addr[17:16] == BLK_EEPROM && !eep_open_r))
    begin
      chk_prot = 1'b1;
    end
  end

  always_comb
  begin
    case (state_r)
      ST_IDLE: state_nxt = launch ? ST_CHECK : ST_IDLE;
      ST_CHECK: state_nxt = (chk_acc || chk_prot) ? ST_DONE : ST_ERASE;
      ST_ERASE: state_nxt = ARRAY_DONE ? ST_VERIFY : ST_ERASE;
      ST_VERIFY: state_nxt = ARRAY_DONE ? ST_DONE : ST_VERIFY;
      ST_DONE: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state_r <= ST_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // array request
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ARRAY_REQ <= '0;
    end
    else
    begin
      ARRAY_REQ.erase <= (state_nxt == ST_ERASE);
      ARRAY_REQ.verify <= (state_nxt == ST_VERIFY);
      ARRAY_REQ.sector <= (cmd_code == CMD_ERASE_SECTOR);
      ARRAY_REQ.addr <= cmd_addr;
    end
  end

  // error flags: access and protection write one to clear, set wins; verify flags cleared at launch
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      acc_err_r <= 1'b0;
      prot_err_r <= 1'b0;
      verr_hi_r <= 1'b0;
      verr_lo_r <= 1'b0;
    end
    else
    begin
      if (state_r == ST_CHECK && chk_acc)
      begin
        acc_err_r <= 1'b1;
      end
      else if (wr_pend_r && wr_sel_r == SEL_STATUS && HWDATA[ACC_BIT])
      begin
        acc_err_r <= 1'b0;
      end
      if (state_r == ST_CHECK && chk_prot)
      begin
        prot_err_r <= 1'b1;
      end
      else if (wr_pend_r && wr_sel_r == SEL_STATUS && HWDATA[PROT_BIT])
      begin
        prot_err_r <= 1'b0;
      end
      if (state_r == ST_VERIFY && ARRAY_DONE)
      begin
        verr_hi_r <= ARRAY_VERIFY_ERR;
        verr_lo_r <= ARRAY_UNCORR_ERR;
      end
      else if (launch)
      begin
        verr_hi_r <= 1'b0;
        verr_lo_r <= 1'b0;
      end
    end
  end

  // eeprom protection register
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      eep_open_r <= EEPROM_PROTECTION_RESET[OPEN_BIT];
      eep_size_r <= EEPROM_PROTECTION_RESET[SIZE_W-1:0];
    end
    else if (CFG_LOAD)
    begin
      eep_open_r <= CFG_EEPROM_PROTECTION_BYTE[OPEN_BIT];
      eep_size_r <= CFG_EEPROM_PROTECTION_BYTE[SIZE_W-1:0];
    end
    else if (wr_pend_r && wr_sel_r == SEL_EEPROM_PROTECTION && wr_lane_r[0])
    begin
      if (HWDATA[SIZE_W-1:0] > eep_size_r)
      begin
        eep_size_r <= HWDATA[SIZE_W-1:0];
      end
      if (!HWDATA[OPEN_BIT])
      begin
        eep_open_r <= 1'b0;
      end
    end
  end

  // security register, no software write path
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      sec_r <= SEC_ALL_SET;
    end
    else if (CFG_LOAD)
    begin
      sec_r <= CFG_SEC_DBL_FAULT ? SEC_ALL_SET : CFG_SEC_BYTE;
    end
    else if (BACKDOOR_UNSECURE && BACKDOOR_KEY_EN)
    begin
      sec_r[1:0] <= SEC_UNSECURED;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      BACKDOOR_KEY_EN <= 1'b0;
    end
    else
    begin
      BACKDOOR_KEY_EN <= (sec_r[KEY_LSB+1:KEY_LSB] == KEY_ENABLED);
    end
  end

  assign CMD_COMPLETE = complete_r;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!ARST_N);

  a_size_only_grows: assert property (!$past(CFG_LOAD) |-> eep_size_r >= $past(eep_size_r))
    else $error("protected size shrank");
  a_open_never_sets: assert property (!$past(CFG_LOAD) && !$past(eep_open_r) |-> !eep_open_r)
    else $error("protection open bit set again");
  a_launch_clears_flag: assert property (launch |=> !complete_r && state_r == ST_CHECK)
    else $error("launch did not clear complete flag");
  a_params_frozen: assert property (!complete_r && !$past(complete_r) |-> $stable(param_r))
    else $error("parameters changed while busy");
  a_hidden_idx_zero: assert property (bus_acc && !HWRITE && reg_sel(HADDR) == SEL_DATA && index_r > IDX_LAST |=> HRDATA == 32'h0000_0000)
    else $error("hidden parameter word read nonzero");
  a_idx_error: assert property (state_r == ST_CHECK && launch_idx_r != IDX_ADDR |=> acc_err_r && state_r == ST_DONE ##1 complete_r)
    else $error("bad index at launch not flagged");
  a_prot_no_erase: assert property (state_r == ST_CHECK && chk_prot |=> prot_err_r && !ARRAY_REQ.erase [*2])
    else $error("protected block erased");
  a_done_sets_flag: assert property (state_r == ST_VERIFY && ARRAY_DONE |-> !complete_r ##2 complete_r)
    else $error("completion not set after verify");
  a_verify_status: assert property (state_r == ST_VERIFY && ARRAY_DONE |=> verr_hi_r == $past(ARRAY_VERIFY_ERR) && verr_lo_r == $past(ARRAY_UNCORR_ERR))
    else $error("verify status mismatch");
  a_dbl_fault_secure: assert property (CFG_LOAD && CFG_SEC_DBL_FAULT |=> sec_r == SEC_ALL_SET ##1 !BACKDOOR_KEY_EN)
    else $error("double fault did not secure");
  a_backdoor_force: assert property (!CFG_LOAD && BACKDOOR_UNSECURE && BACKDOOR_KEY_EN |=> sec_r[1:0] == SEC_UNSECURED)
    else $error("security field not forced");

  c_block_erase_done: cover property (state_r == ST_VERIFY && ARRAY_DONE && cmd_code == CMD_ERASE_BLOCK);
  c_sector_erase_done: cover property (state_r == ST_VERIFY && ARRAY_DONE && cmd_code == CMD_ERASE_SECTOR);
  c_prot_violation: cover property (state_r == ST_CHECK && chk_prot);
  c_backdoor_unsecure: cover property (BACKDOOR_UNSECURE && BACKDOOR_KEY_EN);
endmodule

// ---- verification/fcp_tb.sv ----
`timescale 1ns/1ps
module tb;
  import fcp_pkg::*;
  localparam logic [63:0] MODE_MASK = 64'hFFFF_FFFF_FDFF_FFFF;
  logic REF_CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HWDATA = 32'h0;
  logic HREADY;
  logic [31:0] HRDATA;
  logic HREADYOUT;
  logic HRESP;
  logic CFG_LOAD = 1'b0;
  logic [7:0] CFG_EEPROM_PROTECTION_BYTE = 8'h0;
  logic [7:0] CFG_SEC_BYTE = 8'h0;
  logic CFG_SEC_DBL_FAULT = 1'b0;
  logic [1:0] OP_MODE = 2'h0;
  logic PFLASH_PROTECTED = 1'b0;
  logic BACKDOOR_UNSECURE = 1'b0;
  fcp_array_req_t ARRAY_REQ;
  logic ARRAY_DONE = 1'b0;
  logic ARRAY_VERIFY_ERR = 1'b0;
  logic ARRAY_UNCORR_ERR = 1'b0;
  logic CMD_COMPLETE;
  logic BACKDOOR_KEY_EN;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_erase = 0;
  int n_verify = 0;
  int dcnt = 0;
  logic erase_q = 1'b0;
  logic verify_q = 1'b0;
  fcp_array_req_t last_req;
  int i;

  assign HREADY = HREADYOUT;

  fcp_top #(.CMD_MODE_MASK(MODE_MASK)) fcp_top_inst (.REF_CLK(REF_CLK), .ARST_N(ARST_N),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
    .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .CFG_LOAD(CFG_LOAD), .CFG_EEPROM_PROTECTION_BYTE(CFG_EEPROM_PROTECTION_BYTE),
    .CFG_SEC_BYTE(CFG_SEC_BYTE), .CFG_SEC_DBL_FAULT(CFG_SEC_DBL_FAULT), .OP_MODE(OP_MODE),
    .PFLASH_PROTECTED(PFLASH_PROTECTED), .BACKDOOR_UNSECURE(BACKDOOR_UNSECURE),
    .ARRAY_REQ(ARRAY_REQ), .ARRAY_DONE(ARRAY_DONE), .ARRAY_VERIFY_ERR(ARRAY_VERIFY_ERR),
    .ARRAY_UNCORR_ERR(ARRAY_UNCORR_ERR), .CMD_COMPLETE(CMD_COMPLETE),
    .BACKDOOR_KEY_EN(BACKDOOR_KEY_EN));

  always #5 REF_CLK = ~REF_CLK;

  // array timing stand-in: ends each erase or verify step after a few cycles
  always @(posedge REF_CLK)
  begin
    cyc <= cyc + 1;
    erase_q <= ARRAY_REQ.erase;
    verify_q <= ARRAY_REQ.verify;
    if (ARRAY_REQ.erase && !erase_q)
      n_erase <= n_erase + 1;
    if (ARRAY_REQ.verify && !verify_q)
      n_verify <= n_verify + 1;
    if (ARRAY_REQ.erase)
      last_req <= ARRAY_REQ;
    if (ARRAY_DONE)
    begin
      ARRAY_DONE <= 1'b0;
      dcnt <= 0;
    end
    else if (ARRAY_REQ.erase || ARRAY_REQ.verify)
    begin
      dcnt <= dcnt + 1;
      if (dcnt == 4)
        ARRAY_DONE <= 1'b1;
    end
    if (cyc == 20000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (error_cnt == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [2:0] sz,
    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge REF_CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    HSIZE <= sz;
    @(posedge REF_CLK);
    while (HREADYOUT !== 1'b1)
      @(posedge REF_CLK);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    @(posedge REF_CLK);
    while (HREADYOUT !== 1'b1)
      @(posedge REF_CLK);
    rd = HRDATA;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [2:0] sz = 3'h2);
    logic [31:0] x;
    bus(a, 1'b1, sz, d, x);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string m);
    logic [31:0] x;
    bus(a, 1'b0, 3'h2, 32'h0, x);
    chk(x, exp, m);
    chk({31'h0, HRESP}, 32'h0, "okay response");
  endtask

  task automatic cfg(input logic [7:0] ep, input logic [7:0] sec, input logic dbl);
    @(posedge REF_CLK);
    CFG_LOAD <= 1'b1;
    CFG_EEPROM_PROTECTION_BYTE <= ep;
    CFG_SEC_BYTE <= sec;
    CFG_SEC_DBL_FAULT <= dbl;
    @(posedge REF_CLK);
    CFG_LOAD <= 1'b0;
    CFG_SEC_DBL_FAULT <= 1'b0;
  endtask

  // load words, launch, poke a word while busy if no access or protection error is expected, wait, check status and array steps
  task automatic run_cmd(input logic [7:0] cmd, input logic [1:0] blk, input logic [15:0] ad,
    input logic [2:0] ix, input logic [7:0] exp_st);
    logic [31:0] st;
    int e0;
    int v0;
    logic ok;
    e0 = n_erase;
    v0 = n_verify;
    ok = (exp_st[5:4] == 2'h0);
    wr(OFF_INDEX, 32'h0);
    wr(OFF_DATA, {16'h0, cmd, 6'h0, blk});
    wr(OFF_INDEX, 32'h1);
    wr(OFF_DATA, {16'h0, ad});
    wr(OFF_INDEX, {29'h0, ix});
    wr(OFF_STATUS, 32'h80);
    if (ok)
      wr(OFF_DATA, 32'hFFFF);
    st = 32'h0;
    while (st[CMPL_BIT] !== 1'b1)
      bus(OFF_STATUS, 1'b0, 3'h2, 32'h0, st);
    chk(st, {24'h0, exp_st}, "status after command");
    chk(CMD_COMPLETE, 32'h1, "complete output");
    chk(n_erase - e0, ok ? 1 : 0, "erase steps");
    chk(n_verify - v0, ok ? 1 : 0, "verify steps");
    if (ok)
      rdchk(OFF_DATA, {16'h0, ad}, "parameter frozen while busy");
    wr(OFF_STATUS, 32'h30);
  endtask

  initial
  begin
    repeat (4) @(posedge REF_CLK);
    ARST_N <= 1'b1;
    rdchk(OFF_STATUS, 32'h80, "status reset");
    rdchk(OFF_EEPROM_PROTECTION, 32'h80, "eeprom protection reset");
    rdchk(OFF_SEC, 32'hFF, "security reset");
    rdchk(OFF_INDEX, 32'h0, "index reset");
    wr(8'h20, 32'hFFFF_FFFF);
    rdchk(8'h20, 32'h0, "unmapped offset");
    cfg(8'h85, 8'h81, 1'b0);
    rdchk(OFF_EEPROM_PROTECTION, 32'h85, "eeprom protection load");
    rdchk(OFF_SEC, 32'h81, "security load");
    chk(BACKDOOR_KEY_EN, 32'h1, "key enable on 10");
    for (i = 0; i < 8; i++)
    begin
      wr(OFF_INDEX, i);
      wr(OFF_DATA, 32'hA500 + i);
    end
    for (i = 0; i < 8; i++)
    begin
      wr(OFF_INDEX, i);
      rdchk(OFF_DATA, (i < 6) ? 32'hA500 + i : 32'h0, "parameter word");
    end
    wr(OFF_INDEX, 32'h2);
    wr(8'h04, 32'h3C3C_3C3C, 3'h0);
    wr(8'h05, 32'hC3C3_C3C3, 3'h0);
    rdchk(OFF_DATA, 32'hC33C, "byte writes");
    ARRAY_VERIFY_ERR <= 1'b1;
    ARRAY_UNCORR_ERR <= 1'b1;
    run_cmd(CMD_ERASE_BLOCK, BLK_PFLASH, 16'h0008, IDX_ADDR, 8'h83);
    ARRAY_UNCORR_ERR <= 1'b0;
    run_cmd(CMD_ERASE_SECTOR, BLK_PFLASH, 16'h1230, IDX_ADDR, 8'h82);
    chk(last_req, {1'b1, 1'b0, 1'b1, 2'h3, 16'h1230}, "sector erase request");
    ARRAY_VERIFY_ERR <= 1'b0;
    run_cmd(CMD_ERASE_BLOCK, BLK_PFLASH, 16'h0000, IDX_CMD, 8'hA0);
    run_cmd(CMD_ERASE_BLOCK, 2'h1, 16'h0000, IDX_ADDR, 8'hA0);
    run_cmd(CMD_ERASE_BLOCK, BLK_PFLASH, 16'h0004, IDX_ADDR, 8'hA0);
    run_cmd(CMD_ERASE_BLOCK, BLK_EEPROM, 16'h0001, IDX_ADDR, 8'hA0);
    run_cmd(CMD_ERASE_SECTOR, BLK_EEPROM, 16'h0000, IDX_ADDR, 8'hA0);
    run_cmd(8'h05, BLK_PFLASH, 16'h0000, IDX_ADDR, 8'hA0);
    OP_MODE <= 2'h1;
    run_cmd(CMD_ERASE_BLOCK, BLK_PFLASH, 16'h0000, IDX_ADDR, 8'hA0);
    run_cmd(CMD_ERASE_SECTOR, BLK_PFLASH, 16'h0000, IDX_ADDR, 8'h80);
    OP_MODE <= 2'h0;
    PFLASH_PROTECTED <= 1'b1;
    run_cmd(CMD_ERASE_BLOCK, BLK_PFLASH, 16'h0000, IDX_ADDR, 8'h90);
    PFLASH_PROTECTED <= 1'b0;
    run_cmd(CMD_ERASE_BLOCK, BLK_EEPROM, 16'h0002, IDX_ADDR, 8'h80);
    wr(OFF_EEPROM_PROTECTION, 32'h83);
    rdchk(OFF_EEPROM_PROTECTION, 32'h85, "smaller size ignored");
    wr(OFF_EEPROM_PROTECTION, 32'h87);
    rdchk(OFF_EEPROM_PROTECTION, 32'h87, "larger size taken");
    wr(OFF_EEPROM_PROTECTION, 32'h07);
    rdchk(OFF_EEPROM_PROTECTION, 32'h07, "open bit cleared");
    wr(OFF_EEPROM_PROTECTION, 32'h87);
    rdchk(OFF_EEPROM_PROTECTION, 32'h07, "open bit stays clear");
    run_cmd(CMD_ERASE_BLOCK, BLK_EEPROM, 16'h0002, IDX_ADDR, 8'h90);
    wr(OFF_SEC, 32'h00);
    rdchk(OFF_SEC, 32'h81, "security write ignored");
    @(posedge REF_CLK);
    BACKDOOR_UNSECURE <= 1'b1;
    @(posedge REF_CLK);
    BACKDOOR_UNSECURE <= 1'b0;
    rdchk(OFF_SEC, 32'h82, "backdoor unsecure");
    for (i = 0; i < 4; i++)
    begin
      cfg(8'h80, {i[1:0], 6'h01}, 1'b0);
      rdchk(OFF_SEC, {24'h0, i[1:0], 6'h01}, "security reload");
      chk(BACKDOOR_KEY_EN, (i == 2) ? 32'h1 : 32'h0, "key enable decode");
    end
    cfg(8'h80, 8'h81, 1'b1);
    rdchk(OFF_SEC, 32'hFF, "double fault load");
    chk(BACKDOOR_KEY_EN, 32'h0, "key disabled after fault");
    stop_test();
  end
endmodule
